/* rtl/asp_frame_port.v */
// serial frame port of an eight-channel sampling converter with register slave
// assumes frame select, serial clock and data in arrive asynchronously to clk_in
// and toggle slowly against it (serial clock at least four clk_in periods per half)
//
// What this block does
// - frame select fall: hold, drive output, start
// - ordinary frame: track on fourteenth falling edge
// - sequence-list frame: hold until frame select rises
// - float output on sixteenth falling edge
// - early frame rise: abort, float, keep control
// - word: zero, three-bit channel tag, result
// - zero at select fall, tag top bit first
// - last bit out on fifteenth falling edge
// - first twelve edges load control if write
// - sequence-list path: capture all sixteen edges
// - commit sequence list at rise, track first
// - 8-bit variant: result then four zeros
// - 10-bit variant: result then two zeros
// - 12-bit variant: full result, no padding
// - serial clock steps conversion and shifting
// - sequence path after seq off, select on
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "asp_regs.vh"

module asp_frame_port #(
    parameter RES_BITS = 12,
    parameter CNT_WIDTH = 16
) (
    input wire clk_in,
    input wire rst_in,
    input wire [5:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    input wire cs_n_in,
    input wire sclk_in,
    input wire din_in,
    output reg dout_out,
    output reg dout_oe_out,
    output reg sample_hold_out,
    output reg frame_active_out
);

    // ------------------------------------------------------------------------
    // constants and helpers
    // ------------------------------------------------------------------------
    localparam integer PAD = 12 - RES_BITS;
    localparam [11:0] RES_MASK = ~(12'hfff << RES_BITS);

    // next set channel after cur in mask, wrapping; stays if mask empty
    function [2:0] next_chan;
        input [2:0] cur;
        input [7:0] mask;
        integer i;
        reg [2:0] pick;
        reg [2:0] cand;
        reg found;
        begin
            pick = cur;
            cand = cur;
            found = 1'b0;
            for (i = 1; i < 9; i = i + 1) begin
                cand = cur + i[2:0]; // three bits wrap past channel seven
                if (!found && mask[cand]) begin
                    pick = cand;
                    found = 1'b1;
                end
            end
            next_chan = pick;
        end
    endfunction

    // both sequence halves merged, bit n selects channel n
    function [7:0] seq_mask;
        input [15:0] list;
        begin
            seq_mask = list[15:8] | list[7:0];
        end
    endfunction

    // counter step shared by the frame and abort counters
    function [CNT_WIDTH-1:0] cnt_inc;
        input [CNT_WIDTH-1:0] val;
        begin
            cnt_inc = val + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
        end
    endfunction

    // true when the fall now seen is fall number n of the frame
    function is_fall;
        input [4:0] cnt;
        input [4:0] n;
        begin
            is_fall = (cnt == n - 5'h01);
        end
    endfunction

    // ------------------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------------------
    wire [2:0] pins_s;
    wire cs_n_s;
    wire sclk_s;
    wire din_s;
    reg cs_n_p_q;
    reg sclk_p_q;

    // select, clock and data share one synchroniser, keeping their order
    asp_sync2 #(
        .WIDTH(3),
        .RESET_VAL(3'h7)
    ) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in({cs_n_in, sclk_in, din_in}),
        .sync_out(pins_s)
    );

    assign cs_n_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign din_s = pins_s[0];

    // previous synchronised levels for edge finding
    always @(posedge clk_in) begin
        if (rst_in) begin
            cs_n_p_q <= 1'h1;
            sclk_p_q <= 1'h1;
        end else begin
            cs_n_p_q <= cs_n_s;
            sclk_p_q <= sclk_s;
        end
    end

    // edges of the synchronised pins, one cycle wide
    wire cs_fall = cs_n_p_q & ~cs_n_s;
    wire cs_rise = ~cs_n_p_q & cs_n_s;
    wire sclk_fall = sclk_p_q & ~sclk_s;

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    reg [11:0] ctrl_q;
    reg [15:0] seqlist_q;
    reg link_en_q;
    reg [2:0] chan_q;
    reg active_q;
    reg [4:0] edge_cnt_q;
    reg [15:0] tx_q;
    reg [15:0] rx_q;
    reg [11:0] ctrl_pend_q;
    reg ctrl_pend_vld_q;
    reg seqlist_next_q;
    reg seqlist_frame_q;
    reg [CNT_WIDTH-1:0] frames_q;
    reg [CNT_WIDTH-1:0] aborts_q;
    reg bus_stage_q;

    wire [11:0] mem_a_data;
    wire [11:0] mem_b_data;
    wire bus_req = avs_read_in | avs_write_in;
    wire bus_wr = avs_write_in & ~avs_waitrequest_out;
    wire [3:0] bus_idx = avs_address_in[5:2];
    wire bus_res = avs_address_in[`ASP_RESULT_SEL_BIT];
    wire [1:0] mem_lanes = (bus_wr && bus_res) ? avs_byteenable_in[1:0] : 2'h0;

    // ------------------------------------------------------------------------
    // result store, port a for the bus, port b for the current channel
    // ------------------------------------------------------------------------
    // port a follows the bus address; two wait states cover its latency
    asp_result_mem #(
        .DEPTH_LOG2(3),
        .WIDTH(12)
    ) u_mem (
        .clk_in(clk_in),
        .wr_addr_in(avs_address_in[4:2]),
        .wr_lane_in(mem_lanes),
        .wr_data_in(avs_writedata_in[11:0]),
        .rd_a_addr_in(avs_address_in[4:2]),
        .rd_a_data_out(mem_a_data),
        .rd_b_addr_in(chan_q),
        .rd_b_data_out(mem_b_data)
    );

    // outgoing word: zero, tag, result left aligned, zero fill below
    reg [11:0] res_field;
    wire [15:0] out_word = {1'h0, chan_q, res_field};

    // result justified to the variant width
    always @* begin
        res_field = (mem_b_data & RES_MASK) << PAD;
    end

    // ------------------------------------------------------------------------
    // frame engine
    // ------------------------------------------------------------------------
    always @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_q <= `ASP_CTRL_RESET;
            seqlist_q <= `ASP_SEQLIST_RESET;
            chan_q <= 3'h0;
            active_q <= 1'h0;
            edge_cnt_q <= 5'h00;
            tx_q <= 16'h0000;
            rx_q <= 16'h0000;
            ctrl_pend_q <= 12'h000;
            ctrl_pend_vld_q <= 1'h0;
            seqlist_next_q <= 1'h0;
            seqlist_frame_q <= 1'h0;
            frames_q <= {CNT_WIDTH{1'b0}};
            aborts_q <= {CNT_WIDTH{1'b0}};
            dout_out <= 1'h0;
            dout_oe_out <= 1'h0;
            sample_hold_out <= 1'h0;
            frame_active_out <= 1'h0;
        end else if (cs_fall && link_en_q) begin
            // sample, hold, leave high impedance, present leading zero
            active_q <= 1'h1;
            frame_active_out <= 1'h1;
            sample_hold_out <= 1'h1;
            dout_oe_out <= 1'h1;
            dout_out <= out_word[15];
            tx_q <= {out_word[14:0], 1'h0};
            edge_cnt_q <= 5'h00;
            rx_q <= 16'h0000;
            ctrl_pend_vld_q <= 1'h0;
            seqlist_frame_q <= seqlist_next_q;
        end else if (active_q && sclk_fall && !cs_rise && edge_cnt_q < `ASP_EDGE_LAST) begin
            // one falling serial clock edge: shift out and in
            // a select rise in the same cycle wins, so an abort is never lost
            edge_cnt_q <= edge_cnt_q + 5'h01;
            dout_out <= tx_q[15];
            tx_q <= {tx_q[14:0], 1'h0};
            rx_q <= {rx_q[14:0], din_s};
            if (is_fall(edge_cnt_q, `ASP_EDGE_CTRL_LOAD) && !seqlist_frame_q) begin
                // first received bit decides whether the word is kept
                if (rx_q[10]) begin
                    ctrl_pend_q <= {rx_q[10:0], din_s};
                    ctrl_pend_vld_q <= 1'h1;
                end
            end
            if (is_fall(edge_cnt_q, `ASP_EDGE_TRACK) && !seqlist_frame_q) begin
                sample_hold_out <= 1'h0;
            end
            if (is_fall(edge_cnt_q, `ASP_EDGE_LAST)) begin
                dout_oe_out <= 1'h0;
            end
        end else if (active_q && cs_rise) begin
            // commits happen only here, so an aborted frame changes only the abort count
            active_q <= 1'h0;
            frame_active_out <= 1'h0;
            dout_oe_out <= 1'h0;
            if (edge_cnt_q != `ASP_EDGE_LAST) begin
                // early rise: conversion dropped, nothing committed
                // an aborted list frame leaves the list path armed
                sample_hold_out <= 1'h0;
                aborts_q <= cnt_inc(aborts_q);
            end else begin
                frames_q <= cnt_inc(frames_q);
                if (seqlist_frame_q) begin
                    // commit list and track first chosen channel
                    seqlist_q <= rx_q;
                    seqlist_next_q <= 1'h0;
                    sample_hold_out <= 1'h0;
                    chan_q <= next_chan(3'h7, seq_mask(rx_q));
                end else if (ctrl_pend_vld_q) begin
                    ctrl_q <= ctrl_pend_q;
                    seqlist_next_q <= ~ctrl_pend_q[`ASP_CTRL_SEQ_EN]
                        & ctrl_pend_q[`ASP_CTRL_SEQLIST_SEL];
                    chan_q <= ctrl_pend_q[`ASP_CTRL_ADDR_HI:`ASP_CTRL_ADDR_LO];
                end else if (ctrl_q[`ASP_CTRL_SEQ_EN] && ctrl_q[`ASP_CTRL_SEQLIST_SEL]) begin
                    // sequencer steps to the next listed channel
                    chan_q <= next_chan(chan_q, seq_mask(seqlist_q));
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // avalon-mm slave
    // ------------------------------------------------------------------------
    reg [31:0] rd_mux;

    // engine flags in status bit order, channel in bits 6:4
    wire [7:0] status_bits = {seqlist_frame_q, chan_q, seqlist_next_q, dout_oe_out,
        active_q, sample_hold_out};

    // read data selection by word index
    always @* begin
        rd_mux = 32'h0000_0000;
        if (bus_res) begin
            rd_mux = {20'h0_0000, mem_a_data};
        end else begin
            case (bus_idx)
                `ASP_IDX_CTRL: rd_mux = {20'h0_0000, ctrl_q};
                `ASP_IDX_SEQLIST: rd_mux = {16'h0000, seqlist_q};
                `ASP_IDX_STATUS: rd_mux = {24'h00_0000, status_bits};
                `ASP_IDX_FRAMES: rd_mux = {{(32-CNT_WIDTH){1'b0}}, frames_q};
                `ASP_IDX_ABORTS: rd_mux = {{(32-CNT_WIDTH){1'b0}}, aborts_q};
                `ASP_IDX_CONFIG: rd_mux = {31'h0000_0000, link_en_q};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // two wait cycles let the result store answer, then one ready cycle;
    // the stage flag marks the second wait cycle and clears at the end of the ready cycle,
    // so waitrequest is low for exactly one cycle per request
    always @(posedge clk_in) begin
        if (rst_in) begin
            avs_waitrequest_out <= 1'h1;
            avs_readdata_out <= 32'h0000_0000;
            bus_stage_q <= 1'h0;
        end else if (!avs_waitrequest_out) begin
            avs_waitrequest_out <= 1'h1;
            bus_stage_q <= 1'h0;
        end else if (bus_req && bus_stage_q) begin
            avs_waitrequest_out <= 1'h0;
            avs_readdata_out <= avs_read_in ? rd_mux : 32'h0000_0000;
        end else if (bus_req) begin
            bus_stage_q <= 1'h1;
        end
    end

    // config register: link enable gates new frames
    // a frame already running finishes even when the link is switched off
    always @(posedge clk_in) begin
        if (rst_in) begin
            link_en_q <= `ASP_CFG_RESET;
        end else if (bus_wr && !bus_res && bus_idx == `ASP_IDX_CONFIG
                     && avs_byteenable_in[0]) begin
            link_en_q <= avs_writedata_in[`ASP_CFG_LINK_EN];
        end
    end

endmodule
`default_nettype wire

/* rtl/asp_regs.vh */
// register offsets, field positions and reset values of the serial frame port
// assumes byte addresses on a 32-bit avalon-mm slave
`ifndef ASP_REGS_VH
`define ASP_REGS_VH

// ----------------------------------------------------------------------------
// register word indices (byte address bits 5:2)
// ----------------------------------------------------------------------------
`define ASP_IDX_CTRL 4'h0
`define ASP_IDX_SEQLIST 4'h1
`define ASP_IDX_STATUS 4'h2
`define ASP_IDX_FRAMES 4'h3
`define ASP_IDX_ABORTS 4'h4
`define ASP_IDX_CONFIG 4'h5
// result slots sit at byte address 0x20 + 4 * channel
`define ASP_RESULT_SEL_BIT 5

// ----------------------------------------------------------------------------
// control word fields, first received bit is bit 11
// ----------------------------------------------------------------------------
`define ASP_CTRL_WRITE 11
`define ASP_CTRL_SEQ_EN 10
`define ASP_CTRL_ADDR_HI 8
`define ASP_CTRL_ADDR_LO 6
`define ASP_CTRL_SEQLIST_SEL 3
`define ASP_CTRL_RESET 12'h000
`define ASP_SEQLIST_RESET 16'h0000

// ----------------------------------------------------------------------------
// frame timing in serial clock falling edges
// ----------------------------------------------------------------------------
`define ASP_EDGE_CTRL_LOAD 5'h0c
`define ASP_EDGE_TRACK 5'h0e
`define ASP_EDGE_LAST 5'h10

// ----------------------------------------------------------------------------
// config register
// ----------------------------------------------------------------------------
`define ASP_CFG_LINK_EN 0
`define ASP_CFG_RESET 1'h1

`endif

/* rtl/asp_result_mem.v */
// per-channel result store: one write port with two byte lanes, two read ports
// assumes read data are wanted one clock after the address
`timescale 1ns/100ps
`default_nettype none

module asp_result_mem #(
    parameter DEPTH_LOG2 = 3,
    parameter WIDTH = 12
) (
    input wire clk_in,
    input wire [DEPTH_LOG2-1:0] wr_addr_in,
    input wire [1:0] wr_lane_in,
    input wire [WIDTH-1:0] wr_data_in,
    input wire [DEPTH_LOG2-1:0] rd_a_addr_in,
    output reg [WIDTH-1:0] rd_a_data_out,
    input wire [DEPTH_LOG2-1:0] rd_b_addr_in,
    output reg [WIDTH-1:0] rd_b_data_out
);

    reg [WIDTH-1:0] mem_q [0:(1<<DEPTH_LOG2)-1];

    // lane 0 covers bits 7:0, lane 1 the bits above
    always @(posedge clk_in) begin
        if (wr_lane_in[0]) begin
            mem_q[wr_addr_in][7:0] <= wr_data_in[7:0];
        end
        if (wr_lane_in[1]) begin
            mem_q[wr_addr_in][WIDTH-1:8] <= wr_data_in[WIDTH-1:8];
        end
        rd_a_data_out <= mem_q[rd_a_addr_in];
        rd_b_data_out <= mem_q[rd_b_addr_in];
    end

endmodule
`default_nettype wire

/* rtl/asp_sync2.v */
// two flip-flop synchroniser for a bundle of asynchronous levels
// assumes each bit is an independent level from outside the clock domain
`timescale 1ns/100ps
`default_nettype none

module asp_sync2 #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    input wire clk_in,
    input wire rst_in,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always @(posedge clk_in) begin
        if (rst_in) begin
            meta_q <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule
`default_nettype wire

/* tb/asp_chk.sv */
// checker for the serial frame port: bus handshake and frame timing
// assumes raw frame pins are sampled on clk_in, bound to the top module
`timescale 1ns/100ps
`default_nettype none
module asp_chk (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic dout_out,
    input wire logic dout_oe_out,
    input wire logic sample_hold_out,
    input wire logic frame_active_out
);
    // ----------------------------------------------------------------
    // helpers: clock falls seen in a frame, cycles since last fall
    // ----------------------------------------------------------------
    logic [4:0] falls_q;
    logic [3:0] age_q;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            falls_q <= 5'h00;
            age_q <= 4'hf;
        end else begin
            if ($fell(cs_n_in)) begin
                falls_q <= 5'h00;
            end else if (!cs_n_in && $fell(sclk_in)) begin
                falls_q <= falls_q + 5'h01;
            end
            if ($fell(sclk_in)) begin
                age_q <= 4'h0;
            end else if (age_q != 4'hf) begin
                age_q <= age_q + 4'h1;
            end
        end
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    // request just raised, not a held one
    sequence s_req_new;
        (avs_read_in || avs_write_in) &&
            !($past(avs_read_in || avs_write_in) && $past(avs_waitrequest_out));
    endsequence
    // line driven, sampler holding, leading zero out
    sequence s_frame_open;
        dout_oe_out && sample_hold_out && !dout_out;
    endsequence
    a_sel_drives: assert property ($fell(cs_n_in) |-> ##[1:5] s_frame_open)
        else $error("frame start not driven");
    a_rise_floats: assert property ($rose(cs_n_in) |-> ##[1:5]
        (!dout_oe_out && !frame_active_out))
        else $error("output not floated after select rise");
    a_float_at_16: assert property ((falls_q == 5'h10 && $past(falls_q) == 5'h0f)
        |-> ##[1:6] !dout_oe_out)
        else $error("output not floated after last fall");
    a_no_early_track: assert property ($fell(sample_hold_out) |->
        (falls_q >= 5'h0e) || cs_n_in)
        else $error("sampler released early");
    a_hold_in_frame: assert property ((frame_active_out && $past(frame_active_out)
        && !cs_n_in && falls_q < 5'h0d) |-> sample_hold_out)
        else $error("sampler not holding in frame");
    a_dout_on_fall: assert property (($changed(dout_out) && dout_oe_out
        && $past(dout_oe_out) && !cs_n_in) |-> age_q <= 4'h6)
        else $error("output moved away from clock fall");
    a_wait_two: assert property (s_req_new |-> avs_waitrequest_out ##1
        avs_waitrequest_out ##1 !avs_waitrequest_out)
        else $error("answer not in third cycle");
    a_wait_one: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("wait low longer than one cycle");
    a_wait_has_req: assert property (!avs_waitrequest_out |-> (avs_read_in || avs_write_in))
        else $error("answer without request");
endmodule
bind asp_frame_port asp_chk u_chk (
    .clk_in(clk_in), .rst_in(rst_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
    .cs_n_in(cs_n_in), .sclk_in(sclk_in), .dout_out(dout_out),
    .dout_oe_out(dout_oe_out), .sample_hold_out(sample_hold_out),
    .frame_active_out(frame_active_out)
);
`default_nettype wire

/* tb/asp_host_model.sv */
// host serial port model: frame select, serial clock and data in
// assumes clk_in at 125 MHz and tasks called just after a clk_in rise
`timescale 1ns/100ps
`default_nettype none
module asp_host_model (
    input wire logic clk_in,
    input wire logic dout_in,
    input wire logic dout_oe_in,
    output logic cs_n_out,
    output logic sclk_out,
    output logic din_out
);
    localparam int HALF = 10; // clk_in cycles per half of 160 ns
    logic last_q = 1'b0;
    logic line;
    // released line shows the inverse of its last driven level
    always @(posedge clk_in) begin
        if (dout_oe_in) last_q <= dout_in;
    end
    assign line = dout_oe_in ? dout_in : ~last_q;
    // idle: select high, clock standing high
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b1;
        din_out = 1'b0;
    end
    // one word msb first over n clocks, select optionally kept low
    task automatic frame(input logic [15:0] w, input int n, input bit keep,
                         output logic [15:0] rx);
        int i;
        begin
            rx = 16'h0000;
            cs_n_out <= 1'b0;
            din_out <= w[15];
            repeat (HALF) @(posedge clk_in);
            for (i = 0; i < n; i++) begin
                rx[15 - i] = line;
                sclk_out <= 1'b0;
                repeat (HALF) @(posedge clk_in);
                sclk_out <= 1'b1;
                if (i < 15) din_out <= w[14 - i];
                repeat (HALF) @(posedge clk_in);
            end
            if (!keep) release_cs();
        end
    endtask
    // end of frame, then a fixed quiet gap in whole clocks
    task automatic release_cs();
        begin
            cs_n_out <= 1'b1;
            din_out <= ~din_out;
            repeat (4 * HALF) @(posedge clk_in);
        end
    endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// testbench: register bus tasks and host frames against the frame port
// assumes the host model and checker are compiled before this file
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk_in;
    logic rst_in;
    logic [5:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] avs_byteenable;
    logic cs_n, sclk, din, dout, dout_oe, hold, active;
    logic [15:0] rx;
    logic [11:0] res [8];
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    int i;
    asp_frame_port #(.RES_BITS(12), .CNT_WIDTH(16)) dut (
        .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address),
        .avs_read_in(avs_read), .avs_write_in(avs_write),
        .avs_writedata_in(avs_writedata), .avs_byteenable_in(avs_byteenable),
        .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_waitrequest),
        .cs_n_in(cs_n), .sclk_in(sclk), .din_in(din), .dout_out(dout),
        .dout_oe_out(dout_oe), .sample_hold_out(hold), .frame_active_out(active));
    asp_host_model host (.clk_in(clk_in), .dout_in(dout), .dout_oe_in(dout_oe),
        .cs_n_out(cs_n), .sclk_out(sclk), .din_out(din));
    // clock, 8 ns period
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    // hang guard
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            checks_done++;
            if (got !== exp) begin
                mismatches++;
                $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // one bus access held until wait sampled low
    task automatic bus(input bit wr, input logic [5:0] a, input logic [31:0] d);
        begin
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= wr;
            avs_read <= !wr;
            @(posedge clk_in);
            while (avs_waitrequest !== 1'b0) @(posedge clk_in);
            q = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            @(posedge clk_in);
        end
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        begin
            bus(1'b0, a, 32'h0000_0000);
            chk(q, e);
        end
    endtask
    task automatic tend(input string s);
        $display("test %s done", s);
    endtask
    task automatic summarize();
        begin
            $display("checks %0d mismatches %0d", checks_done, mismatches);
            if (mismatches == 0 && checks_done > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask
    // main sequence
    initial begin
        rst_in = 1'b1;
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hf;
        for (i = 0; i < 8; i++) res[i] = {~i[2:0], 9'h15a};
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        // reset values, read-only and unmapped places
        bus(1'b1, 6'h00, 32'h0000_0fff);
        bus(1'b1, 6'h18, 32'h0000_ffff);
        rd(6'h00, 32'h0000_0000);
        rd(6'h04, 32'h0000_0000);
        rd(6'h08, 32'h0000_0000);
        rd(6'h14, 32'h0000_0001);
        rd(6'h18, 32'h0000_0000);
        for (i = 0; i < 8; i++) bus(1'b1, {1'b1, i[2:0], 2'b00}, {20'h0_0000, res[i]});
        rd(6'h3c, {20'h0_0000, res[7]});
        tend("registers");
        // control write selects channel five
        host.frame(16'h9400, 16, 1'b0, rx);
        chk({16'h0000, rx}, {16'h0000, 1'b0, 3'h0, res[0]});
        rd(6'h00, 32'h0000_0940);
        // no write flag, select held low after last fall
        host.frame(16'h7ff0, 16, 1'b1, rx);
        rd(6'h08, 32'h0000_0052);
        host.release_cs();
        chk({16'h0000, rx}, {16'h0000, 1'b0, 3'h5, res[5]});
        rd(6'h00, 32'h0000_0940);
        tend("control");
        // abort after eight clocks
        host.frame(16'h8800, 8, 1'b0, rx);
        chk({24'h00_0000, rx[15:8]}, {24'h00_0000, 1'b0, 3'h5, res[5][11:8]});
        rd(6'h00, 32'h0000_0940);
        rd(6'h10, 32'h0000_0001);
        rd(6'h08, 32'h0000_0050);
        tend("abort");
        // sequence-list path: arm, load, commit
        host.frame(16'h8080, 16, 1'b0, rx);
        rd(6'h08, 32'h0000_0008);
        host.frame(16'h2400, 16, 1'b1, rx);
        rd(6'h08, 32'h0000_008b);
        host.release_cs();
        rd(6'h04, 32'h0000_2400);
        host.frame(16'h0000, 16, 1'b0, rx);
        chk({16'h0000, rx}, {16'h0000, 1'b0, 3'h2, res[2]});
        rd(6'h0c, 32'h0000_0005);
        rd(6'h10, 32'h0000_0001);
        tend("sequence");
        // sequencer on: channel two, then five, then wraps to two
        host.frame(16'hc880, 16, 1'b0, rx);
        rd(6'h00, 32'h0000_0c88);
        host.frame(16'h0000, 16, 1'b0, rx);
        chk({16'h0000, rx}, {16'h0000, 1'b0, 3'h2, res[2]});
        host.frame(16'h0000, 16, 1'b0, rx);
        chk({16'h0000, rx}, {16'h0000, 1'b0, 3'h5, res[5]});
        rd(6'h08, 32'h0000_0020);
        tend("sequencer");
        summarize();
    end
endmodule
`default_nettype wire
